// ---- rtl/rtc_pkg.sv ----
// register map, field positions and reset values of the clock core
package rtc_pkg;
  localparam logic [7:0]  OFS_SECONDS     = 8'h00;
  localparam logic [7:0]  OFS_PRESCALER   = 8'h04;
  localparam logic [7:0]  OFS_ALARM       = 8'h08;
  localparam logic [7:0]  OFS_COMP        = 8'h0c;
  localparam logic [7:0]  OFS_CONTROL     = 8'h10;
  localparam logic [7:0]  OFS_STATUS      = 8'h14;
  localparam logic [7:0]  OFS_LOCK        = 8'h18;
  localparam logic [7:0]  OFS_IRQ_EN      = 8'h1c;
  // control fields
  localparam int          CR_SOFT_RESET   = 0;
  localparam int          CR_WAKE_PIN_EN  = 1;
  localparam int          CR_SUPERVISOR   = 2;
  localparam int          CR_UPDATE_MODE  = 3;
  localparam int          CR_OSC_ENABLE   = 8;
  localparam logic [31:0] CR_WRITE_MASK   = 32'h0000_3f0f;
  // status fields
  localparam int          SR_INVALID      = 0;
  localparam int          SR_OVERFLOW     = 1;
  localparam int          SR_ALARM        = 2;
  localparam int          SR_COUNT_EN     = 4;
  // lock fields
  localparam int          LR_COMP_GUARD   = 3;
  localparam int          LR_CTRL_GUARD   = 4;
  localparam int          LR_STATUS_GUARD = 5;
  localparam int          LR_SELF_GUARD   = 6;
  localparam logic [7:0]  LR_FIXED_ONES   = 8'h87;
  // interrupt enable fields
  localparam int          IE_INVALID      = 0;
  localparam int          IE_OVERFLOW     = 1;
  localparam int          IE_ALARM        = 2;
  localparam int          IE_SECONDS      = 4;
  localparam int          IE_WAKE_FORCE   = 7;
  localparam logic [7:0]  IE_WRITE_MASK   = 8'h97;
  // reset values
  localparam logic [31:0] RST_CONTROL     = 32'h0000_0000;
  localparam logic [2:0]  RST_FLAGS       = 3'h1;
  localparam logic [3:0]  RST_LOCKS       = 4'hf;
  localparam logic [7:0]  RST_IRQ_EN      = 8'h07;
  // prescaler bit whose falling edge advances the seconds
  localparam int          PRESC_SEC_BIT   = 14;
  // bus wait states before pready
  localparam logic [1:0]  WAIT_STATES     = 2'h3;
endpackage : rtc_pkg

// ---- rtl/rtc_time_counter_lock_irq.sv ----
// real-time clock core with apb registers, locks and interrupts
`timescale 1ns/100ps
`default_nettype none

module rtc_time_counter_lock_irq
  import rtc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [2:0]  pprot,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        xtal_tick,
  input  wire logic        xtal_present,
  output logic             osc_enable,
  output logic [3:0]       load_cap_sel,
  output logic             clk_out_gate_n,
  output logic             clock_irq,
  output logic             seconds_irq,
  output logic             wake_pin,
  output logic             seconds_clk_out
);

  logic [31:0] seconds_count_q;
  logic [15:0] prescaler_count_q;
  logic [31:0] alarm_value_q;
  logic [31:0] comp_q;
  logic [31:0] control_q;
  logic        count_enable_q;
  logic        alarm_flag_q;
  logic        overflow_flag_q;
  logic        invalid_flag_q;
  logic        lock_self_guard_q;
  logic        status_write_guard_q;
  logic        control_write_guard_q;
  logic        compensation_write_guard_q;
  logic [7:0]  irq_en_q;
  logic [1:0]  wait_q;
  logic        tick_s1_q;
  logic        tick_s2_q;
  logic        tick_s3_q;
  logic        pres_s1_q;
  logic        pres_s2_q;
  logic        sec_pulse_q;

  logic        soft_rst;
  logic        access_done;
  logic        wr_ok;
  logic        bus_err;
  logic        wr_seconds;
  logic        wr_prescaler;
  logic        wr_alarm;
  logic        wr_comp;
  logic        wr_control;
  logic        wr_status;
  logic        wr_lock;
  logic        wr_irq_en;
  logic        count_run;
  logic        step;
  logic [15:0] pres_next;
  logic        sec_inc;
  logic        time_invalid;
  logic        tce_writable;
  logic        tick_rise;
  logic        rd_capture;
  logic [31:0] rd_word;
  logic [31:0] seconds_word;
  logic [31:0] prescaler_word;
  logic [31:0] status_word;
  logic [31:0] lock_word;
  logic [31:0] irq_en_word;

  assign soft_rst = control_q[CR_SOFT_RESET];

  // three wait states on every access
  assign access_done = psel && penable && (wait_q == WAIT_STATES);
  assign pready      = access_done;
  // pprot[0] high marks a privileged access
  assign bus_err     = pwrite && !pprot[0] && !control_q[CR_SUPERVISOR];
  assign pslverr     = access_done && bus_err;
  assign wr_ok       = access_done && pwrite && !bus_err;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 2'h0;
    end else if (!(psel && penable) || access_done) begin
      wait_q <= 2'h0;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end

  // counter registers accept writes only while counting is disabled
  assign wr_seconds   = wr_ok && paddr == OFS_SECONDS && !count_enable_q;
  assign wr_prescaler = wr_ok && paddr == OFS_PRESCALER && !count_enable_q;
  assign wr_alarm     = wr_ok && paddr == OFS_ALARM;
  // locked writes complete normally, data dropped
  assign wr_comp      = wr_ok && paddr == OFS_COMP
                        && compensation_write_guard_q;
  assign wr_control   = wr_ok && paddr == OFS_CONTROL
                        && control_write_guard_q;
  assign wr_status    = wr_ok && paddr == OFS_STATUS;
  assign wr_lock      = wr_ok && paddr == OFS_LOCK && lock_self_guard_q;
  assign wr_irq_en    = wr_ok && paddr == OFS_IRQ_EN;

  // update mode opens count enable when time cannot be running correctly
  assign tce_writable = status_write_guard_q
                        || (control_q[CR_UPDATE_MODE]
                            && (!count_enable_q || invalid_flag_q
                                || overflow_flag_q));

  // soft reset clears control except the reset bit itself, which stays set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= RST_CONTROL;
    end else if (wr_control) begin
      control_q <= pwdata & CR_WRITE_MASK;
    end else if (soft_rst) begin
      control_q <= RST_CONTROL | (32'h1 << CR_SOFT_RESET);
    end
  end

  assign osc_enable     = control_q[CR_OSC_ENABLE];
  assign load_cap_sel   = control_q[13:10];
  assign clk_out_gate_n = control_q[9];

  // crystal tick is asynchronous; edge found after the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
      pres_s1_q <= 1'b0;
      pres_s2_q <= 1'b0;
    end else begin
      tick_s1_q <= xtal_tick;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
      pres_s1_q <= xtal_present;
      pres_s2_q <= pres_s1_q;
    end
  end

  assign tick_rise    = tick_s2_q && !tick_s3_q;
  assign time_invalid = invalid_flag_q || overflow_flag_q;
  assign count_run    = count_enable_q && !time_invalid && pres_s2_q;
  assign step         = count_run && tick_rise;
  assign pres_next    = prescaler_count_q + 16'h1;
  assign sec_inc      = step && prescaler_count_q[PRESC_SEC_BIT]
                        && !pres_next[PRESC_SEC_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler_count_q <= 16'h0;
    end else if (soft_rst) begin
      prescaler_count_q <= 16'h0;
    end else if (wr_prescaler) begin
      prescaler_count_q <= pwdata[15:0];
    end else if (step) begin
      prescaler_count_q <= pres_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seconds_count_q <= 32'h0;
    end else if (soft_rst) begin
      seconds_count_q <= 32'h0;
    end else if (wr_seconds) begin
      seconds_count_q <= pwdata;
    end else if (sec_inc) begin
      seconds_count_q <= seconds_count_q + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_value_q <= 32'h0;
      comp_q        <= 32'h0;
      irq_en_q      <= RST_IRQ_EN;
    end else if (soft_rst) begin
      alarm_value_q <= 32'h0;
      comp_q        <= 32'h0;
      irq_en_q      <= RST_IRQ_EN;
    end else begin
      if (wr_alarm) begin
        alarm_value_q <= pwdata;
      end
      if (wr_comp) begin
        comp_q <= pwdata;
      end
      if (wr_irq_en) begin
        irq_en_q <= pwdata[7:0] & IE_WRITE_MASK;
      end
    end
  end

  // flags: hardware set wins over clearing writes in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_flag_q <= RST_FLAGS[SR_ALARM];
    end else if (soft_rst) begin
      alarm_flag_q <= RST_FLAGS[SR_ALARM];
    end else if (sec_inc && alarm_value_q == seconds_count_q) begin
      alarm_flag_q <= 1'b1;
    end else if (wr_alarm) begin
      alarm_flag_q <= 1'b0;
    end
  end

  // a wrap freezes time until software rewrites the seconds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_q <= RST_FLAGS[SR_OVERFLOW];
    end else if (soft_rst) begin
      overflow_flag_q <= RST_FLAGS[SR_OVERFLOW];
    end else if (sec_inc && seconds_count_q == 32'hffff_ffff) begin
      overflow_flag_q <= 1'b1;
    end else if (wr_seconds) begin
      overflow_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      invalid_flag_q <= RST_FLAGS[SR_INVALID];
    end else if (soft_rst) begin
      invalid_flag_q <= RST_FLAGS[SR_INVALID];
    end else if (wr_seconds) begin
      invalid_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_enable_q <= 1'b0;
    end else if (soft_rst) begin
      count_enable_q <= 1'b0;
    end else if (wr_status && tce_writable) begin
      count_enable_q <= pwdata[SR_COUNT_EN];
    end
  end

  // guards only ever clear by write; control guard ignores soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_write_guard_q <= 1'b1;
    end else if (wr_lock && !pwdata[LR_CTRL_GUARD]) begin
      control_write_guard_q <= 1'b0;
    end
  end

  // the other guards come back on soft reset as well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_self_guard_q <= 1'b1;
    end else if (soft_rst) begin
      lock_self_guard_q <= 1'b1;
    end else if (wr_lock && !pwdata[LR_SELF_GUARD]) begin
      lock_self_guard_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_write_guard_q <= 1'b1;
    end else if (soft_rst) begin
      status_write_guard_q <= 1'b1;
    end else if (wr_lock && !pwdata[LR_STATUS_GUARD]) begin
      status_write_guard_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compensation_write_guard_q <= 1'b1;
    end else if (soft_rst) begin
      compensation_write_guard_q <= 1'b1;
    end else if (wr_lock && !pwdata[LR_COMP_GUARD]) begin
      compensation_write_guard_q <= 1'b0;
    end
  end

  // counters read as zero while time is invalid or overflowed
  assign seconds_word   = time_invalid ? 32'h0
                          : seconds_count_q;
  assign prescaler_word = time_invalid ? 32'h0
                          : {16'h0, prescaler_count_q};
  assign status_word    = {27'h0, count_enable_q, 1'b0, alarm_flag_q,
                           overflow_flag_q, invalid_flag_q};
  assign lock_word      = {24'h0, LR_FIXED_ONES
                           | {1'b0, lock_self_guard_q, status_write_guard_q,
                              control_write_guard_q,
                              compensation_write_guard_q, 3'h0}};
  assign irq_en_word    = {24'h0, irq_en_q};
  // captured a cycle early so prdata is a flop output at pready
  assign rd_capture     = psel && !pwrite && (wait_q == WAIT_STATES - 2'h1);

  always_comb begin
    rd_word = 32'h0;
    case (paddr)
      OFS_SECONDS:   rd_word = seconds_word;
      OFS_PRESCALER: rd_word = prescaler_word;
      OFS_ALARM:     rd_word = alarm_value_q;
      OFS_COMP:      rd_word = comp_q;
      OFS_CONTROL:   rd_word = control_q;
      OFS_STATUS:    rd_word = status_word;
      OFS_LOCK:      rd_word = lock_word;
      OFS_IRQ_EN:    rd_word = irq_en_word;
      default:       rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_capture) begin
      prdata <= rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_pulse_q <= 1'b0;
    end else if (soft_rst) begin
      sec_pulse_q <= 1'b0;
    end else begin
      sec_pulse_q <= sec_inc && irq_en_q[IE_SECONDS];
    end
  end

  assign seconds_irq     = sec_pulse_q;
  assign clock_irq       = (alarm_flag_q && irq_en_q[IE_ALARM])
                           || (overflow_flag_q && irq_en_q[IE_OVERFLOW])
                           || (invalid_flag_q && irq_en_q[IE_INVALID]);
  assign wake_pin        = control_q[CR_WAKE_PIN_EN]
                           && (clock_irq || irq_en_q[IE_WAKE_FORCE]);
  assign seconds_clk_out = prescaler_count_q[PRESC_SEC_BIT];

endmodule : rtc_time_counter_lock_irq

`default_nettype wire

// ---- sim/rtc_xtal_model.sv ----
// crystal oscillator stand-in: ticks only while enabled, after start-up
`timescale 1ns/100ps
`default_nettype none
module rtc_xtal_model (
  input  wire logic en,
  output logic      tick,
  output logic      present
);
  // tick rate scaled up so a second boundary is reachable in a short run
  always begin
    tick = 1'b0;
    present = 1'b0;
    wait (en === 1'b1);
    #2000;
    present = 1'b1;
    while (en === 1'b1) begin
      #130 tick = ~tick;
    end
  end
endmodule : rtc_xtal_model
`default_nettype wire

// ---- sim/rtc_chk.sv ----
// bus timing, flag and read-value checks on the clock core ports
`timescale 1ns/100ps
`default_nettype none
module rtc_chk
  import rtc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [2:0]  pprot,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        clock_irq,
  input wire logic        seconds_irq,
  input wire logic        seconds_clk_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    $rose(penable) && psel;
  endsequence
  sequence s_wait;
    !pready [*3] ##1 pready;
  endsequence
  sequence s_rd(logic [7:0] a);
    pready && psel && penable && !pwrite && paddr == a;
  endsequence
  property p_rdy;
    s_acc |-> s_wait ##1 !pready;
  endproperty
  property p_err;
    pready && pslverr |-> pwrite && !pprot[0];
  endproperty
  property p_rdok;
    pready && !pwrite |-> !pslverr;
  endproperty
  property p_irq_rst;
    $rose(presetn) |-> clock_irq;
  endproperty
  property p_sec_one;
    seconds_irq |=> !seconds_irq;
  endproperty
  property p_sec_src;
    seconds_irq |-> !seconds_clk_out &&
      ($past(seconds_clk_out) || $past(seconds_clk_out, 2));
  endproperty
  property p_lr;
    s_rd(OFS_LOCK) |-> prdata[31:8] == 24'h0 && prdata[7]
      && prdata[2:0] == 3'h7;
  endproperty
  property p_sr;
    s_rd(OFS_STATUS) |-> prdata[31:5] == 27'h0 && !prdata[3];
  endproperty
  property p_ie;
    s_rd(OFS_IRQ_EN) |-> prdata[31:8] == 24'h0;
  endproperty
  a_rdy: assert property (p_rdy) else $error("bus answer timing");
  a_err: assert property (p_err) else $error("error on allowed access");
  a_rdok: assert property (p_rdok) else $error("error on a read");
  a_irq_rst: assert property (p_irq_rst) else $error("irq low after reset");
  a_sec_one: assert property (p_sec_one) else $error("seconds irq wide");
  a_sec_src: assert property (p_sec_src) else $error("seconds irq cause");
  a_lr: assert property (p_lr) else $error("lock fixed bits wrong");
  a_sr: assert property (p_sr) else $error("status fixed bits wrong");
  a_ie: assert property (p_ie) else $error("irq enable high bits");
endmodule : rtc_chk
bind rtc_time_counter_lock_irq rtc_chk rtc_chk_inst (
  .pclk            (pclk),
  .presetn         (presetn),
  .psel            (psel),
  .penable         (penable),
  .pwrite          (pwrite),
  .paddr           (paddr),
  .pprot           (pprot),
  .prdata          (prdata),
  .pready          (pready),
  .pslverr         (pslverr),
  .clock_irq       (clock_irq),
  .seconds_irq     (seconds_irq),
  .seconds_clk_out (seconds_clk_out)
);
`default_nettype wire

// ---- sim/tb_rtc_time_counter_lock_irq.sv ----
// self-checking bench for the clock core over apb
`timescale 1ns/100ps
`default_nettype none
module tb_rtc_time_counter_lock_irq;
  import rtc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        supervisor_access_bit = 1, err_q, pready, pslverr, xtal_tick, xtal_present;
  logic        osc_enable, clk_out_gate_n, clock_irq, seconds_irq;
  logic        wake_pin, seconds_clk_out;
  logic [2:0]  pprot = 3'h1;
  logic [3:0]  load_cap_sel;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  int          n_fail = 0, cmp_count = 0;
  always #20 pclk = ~pclk;
  rtc_time_counter_lock_irq rtc_time_counter_lock_irq_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtal_tick(xtal_tick), .xtal_present(xtal_present),
    .osc_enable(osc_enable), .load_cap_sel(load_cap_sel),
    .clk_out_gate_n(clk_out_gate_n), .clock_irq(clock_irq),
    .seconds_irq(seconds_irq), .wake_pin(wake_pin),
    .seconds_clk_out(seconds_clk_out));
  rtc_xtal_model rtc_xtal_model_inst (.en(osc_enable), .tick(xtal_tick),
    .present(xtal_present));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pprot <= {2'b00, supervisor_access_bit};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk("pready", 32'h1, 32'(pready));
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e = 0);
    apb(1'b1, a, d);
    // let the write land before callers look at the outputs
    @(posedge pclk);
    chk("pslverr", 32'(e), 32'(err_q));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd_q);
  endtask : rd
  task automatic wait_sec;
    int n;
    n = 0;
    while (seconds_irq !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk("seconds_irq", 32'h1, 32'(seconds_irq));
  endtask : wait_sec
  task automatic s_reset;
    rd(OFS_STATUS, 32'h1, "status");
    rd(OFS_LOCK, 32'hff, "lock");
    rd(OFS_IRQ_EN, 32'h7, "irq_en");
    rd(OFS_CONTROL, 32'h0, "control");
    rd(8'h20, 32'h0, "unmapped");
    chk("clock_irq", 32'h1, 32'(clock_irq));
    $display("test reset done");
  endtask : s_reset
  task automatic s_super;
    supervisor_access_bit = 0;
    wr(OFS_IRQ_EN, 32'h0, 1'b1);
    rd(OFS_IRQ_EN, 32'h7, "irq_en");
    supervisor_access_bit = 1;
    wr(OFS_CONTROL, 32'h4);
    supervisor_access_bit = 0;
    wr(OFS_ALARM, 32'h3);
    supervisor_access_bit = 1;
    rd(OFS_ALARM, 32'h3, "alarm");
    $display("test supervisor done");
  endtask : s_super
  task automatic s_swr;
    wr(OFS_LOCK, 32'hdf);
    rd(OFS_LOCK, 32'hdf, "lock");
    wr(OFS_CONTROL, 32'h5);
    rd(OFS_LOCK, 32'hff, "lock");
    rd(OFS_STATUS, 32'h1, "status");
    rd(OFS_ALARM, 32'h0, "alarm");
    rd(OFS_CONTROL, 32'h1, "control");
    wr(OFS_CONTROL, 32'h4);
    rd(OFS_CONTROL, 32'h4, "control");
    $display("test soft reset done");
  endtask : s_swr
  task automatic s_count;
    wr(OFS_CONTROL, 32'h3e06);
    chk("load_cap_sel", 32'hf, 32'(load_cap_sel));
    chk("clk_out_gate_n", 32'h1, 32'(clk_out_gate_n));
    wr(OFS_CONTROL, 32'h3d06);
    chk("osc_enable", 32'h1, 32'(osc_enable));
    chk("clk_out_gate_n", 32'h0, 32'(clk_out_gate_n));
    wr(OFS_PRESCALER, 32'h7ff0);
    wr(OFS_SECONDS, 32'h5);
    wr(OFS_ALARM, 32'h5);
    wr(OFS_IRQ_EN, 32'h97);
    chk("wake_pin", 32'h1, 32'(wake_pin));
    rd(OFS_STATUS, 32'h0, "status");
    chk("clock_irq", 32'h0, 32'(clock_irq));
    // oscillator start-up time before the counter is enabled
    repeat (60) @(posedge pclk);
    wr(OFS_STATUS, 32'h10);
    wr(OFS_SECONDS, 32'h63);
    wait_sec();
    rd(OFS_SECONDS, 32'h6, "seconds");
    rd(OFS_STATUS, 32'h14, "status");
    chk("clock_irq", 32'h1, 32'(clock_irq));
    wr(OFS_ALARM, 32'h0);
    rd(OFS_STATUS, 32'h10, "status");
    $display("test count done");
  endtask : s_count
  task automatic s_overflow;
    wr(OFS_STATUS, 32'h0);
    wr(OFS_PRESCALER, 32'h7ff0);
    wr(OFS_SECONDS, 32'hffffffff);
    wr(OFS_STATUS, 32'h10);
    wait_sec();
    rd(OFS_STATUS, 32'h12, "status");
    rd(OFS_SECONDS, 32'h0, "seconds");
    rd(OFS_PRESCALER, 32'h0, "prescaler");
    wr(OFS_STATUS, 32'h0);
    wr(OFS_SECONDS, 32'h1);
    rd(OFS_STATUS, 32'h0, "status");
    $display("test overflow done");
  endtask : s_overflow
  task automatic s_locks;
    wr(OFS_COMP, 32'h12);
    wr(OFS_CONTROL, 32'h3d0e);
    wr(OFS_LOCK, 32'h0);
    rd(OFS_LOCK, 32'h87, "lock");
    wr(OFS_LOCK, 32'hff);
    rd(OFS_LOCK, 32'h87, "lock");
    wr(OFS_STATUS, 32'h10);
    rd(OFS_STATUS, 32'h10, "status");
    wr(OFS_STATUS, 32'h0);
    rd(OFS_STATUS, 32'h10, "status");
    wr(OFS_CONTROL, 32'h5);
    rd(OFS_CONTROL, 32'h3d0e, "control");
    wr(OFS_COMP, 32'hab);
    rd(OFS_COMP, 32'h12, "comp");
    $display("test locks done");
  endtask : s_locks
  task final_report;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #800000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_super();
    s_swr();
    s_count();
    s_overflow();
    s_locks();
    final_report();
  end
endmodule : tb_rtc_time_counter_lock_irq
`default_nettype wire
